// File: fse_map.vh
// Constants for the floating point status and exception generator
`ifndef FSE_MAP_VH
`define FSE_MAP_VH
// Status vector layout: exception field bits
`define FSE_EX_OVER 0
`define FSE_EX_UNDER 1
`define FSE_EX_TINY 2
`define FSE_EX_ROUNDING_LOSS_FLAG 3
`define FSE_EX_BAD_OPERATION_FLAG 4
`define FSE_EX_DIVZ 5
`define FSE_EX_DENORMAL_INPUT_FLAG 6
`define FSE_EX_INF 7
`define FSE_EX_W 8
// Status vector layout: non-exception field bits
`define FSE_ST_NEG 8
`define FSE_ST_ROUND_CARRY_FLAG 9
`define FSE_ST_PORTB 10
`define FSE_ST_PORTA 11
`define FSE_ST_EQ 12
`define FSE_ST_GT 13
`define FSE_ST_NAN_COMPARE_FLAG 14
`define FSE_ST_W 15
// Status select encodings
`define FSE_SEL_OR 2'h0
`define FSE_SEL_MUL 2'h1
`define FSE_SEL_ALU 2'h2
`define FSE_SEL_NORM 2'h3
// Operation class encodings
`define FSE_OP_ALU 2'h0
`define FSE_OP_MUL 2'h1
`define FSE_OP_CHAIN 2'h2
// Reset values
`define FSE_ST_RST 15'h0000
`define FSE_MASK_RST 8'h00
`endif

// File: fse_source_status.v
// Builds the status vector of one arithmetic source from its raw conditions
`timescale 1ns/1ps
`default_nettype none
`include "fse_map.vh"
module fse_source_status #(
    parameter W = 15
) (
    // Raw conditions of this source
    input wire isCompare,
    input wire opEqual,
    input wire opGreater,
    input wire opNanA,
    input wire opNanB,
    input wire opDenA,
    input wire opDenB,
    input wire resZero,
    input wire resNeg,
    input wire resInf,
    input wire resInexact,
    input wire resTooLarge,
    input wire resTooSmall,
    input wire resTiny,
    input wire invalidOp,
    input wire zeroDivisor,
    input wire roundCarry,
    input wire isMul,
    // Composed status of this source
    output reg [W-1:0] status
);
    // Compose flags; equality doubles as zero detect outside ALU compares
    always @* begin
        status = {W{1'b0}};
        status[`FSE_ST_EQ] = (isCompare && !isMul) ? opEqual : resZero;
        status[`FSE_ST_GT] = isCompare && opGreater;
        status[`FSE_ST_NAN_COMPARE_FLAG] = isCompare && (opNanA || opNanB);
        status[`FSE_EX_DENORMAL_INPUT_FLAG] = isMul && (opDenA || opDenB);
        status[`FSE_EX_TINY] = resTiny;
        status[`FSE_EX_DIVZ] = isMul && zeroDivisor;
        status[`FSE_EX_ROUNDING_LOSS_FLAG] = resInexact;
        status[`FSE_EX_INF] = resInf;
        status[`FSE_ST_NEG] = resNeg;
        status[`FSE_EX_BAD_OPERATION_FLAG] = opNanA || opNanB || invalidOp;
        status[`FSE_EX_OVER] = resTooLarge;
        status[`FSE_ST_ROUND_CARRY_FLAG] = roundCarry;
        status[`FSE_EX_UNDER] = resTooSmall && resInexact;
        // Port flags name the port carrying the NaN or denormal
        status[`FSE_ST_PORTB] = opNanB || (isMul && opDenB);
        status[`FSE_ST_PORTA] = opNanA || (isMul && opDenA);
    end
endmodule // fse_source_status
`default_nettype wire

// File: fse_status_gen.v
// Status and exception generator top: selection, status register, pin gating, mask summary
`timescale 1ns/1ps
`default_nettype none
`include "fse_map.vh"
module fse_status_gen #(
    parameter SW = `FSE_ST_W,
    parameter EW = `FSE_EX_W
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control from the microprogram
    input wire outputStageBypass,
    input wire [1:0] opClass,
    input wire [1:0] statusSelect,
    input wire resultSourceSelect,
    input wire flushMode,
    input wire compareOutputEnable_n,
    input wire statusOutputEnable_n,
    input wire maskLoad,
    input wire [EW-1:0] maskData,
    // ALU raw conditions
    input wire aluCompare,
    input wire aluEqual,
    input wire aluGreater,
    input wire aluNanA,
    input wire aluNanB,
    // ALU result conditions
    input wire aluZero,
    input wire aluNeg,
    input wire aluInf,
    input wire aluInexact,
    // ALU exception conditions
    input wire aluTooLarge,
    input wire aluTooSmall,
    input wire aluDenormOut,
    input wire aluBadInteger,
    input wire aluInvalid,
    input wire aluRoundCarry,
    // Multiplier raw conditions
    input wire mulNanA,
    input wire mulNanB,
    input wire mulDenA,
    input wire mulDenB,
    // Multiplier result conditions
    input wire mulZero,
    input wire mulNeg,
    input wire mulInf,
    input wire mulInexact,
    // Multiplier exception conditions
    input wire mulTooLarge,
    input wire mulTooSmall,
    input wire mulWrapped,
    input wire mulInvalid,
    input wire mulZeroDivisor,
    input wire mulRoundCarry,
    // Comparison pins
    output wire operandsEqualFlag,
    output wire aGreaterFlag,
    output wire nanCompareFlag,
    output wire compareOe,
    // Status pins
    output wire chainedOtherException,
    output wire denormalInputFlag,
    output wire tinyResultFlag,
    output wire zeroDivisorFlag,
    output wire roundingLossFlag,
    output wire unboundedResultFlag,
    output wire badOperationFlag,
    output wire signFlag,
    output wire tooLargeFlag,
    output wire tooSmallFlag,
    output wire roundCarryFlag,
    output wire statusSourceFlag,
    output wire portBException,
    output wire portAException,
    // Summary and status enable
    output wire maskedFaultSummary,
    output wire statusOe,
    // Result forced to zero in flush mode
    output wire flushToZero
);
    // Per-source status vectors
    wire [SW-1:0] aluSt;
    wire [SW-1:0] mulSt;
    wire aluExc;
    wire mulExc;
    // Selected status before the register
    reg [SW-1:0] selSt;
    reg selSrc;
    reg selChex;
    // Status and mask registers
    reg [SW-1:0] stat_q;
    reg src_q;
    reg chained_other_exception_q;
    reg [EW-1:0] mask_q;
    // Presented status and masked exception field
    wire [SW-1:0] outSt;
    wire outSrc;
    wire outChex;
    wire [EW-1:0] outEx;
    wire [EW-1:0] maskedEx;
    // Operation class decode
    wire isAluOp;
    wire isMulOp;
    wire chained;
    wire aluOn;
    wire mulOn;

    // Exception field of a status vector, used on both sources
    function anyException;
        input [SW-1:0] s;
        begin
            anyException = |s[EW-1:0];
        end
    endfunction

    // Picks one source's status vector, used by both selection paths
    function [SW-1:0] pickStatus;
        input useMul;
        input [SW-1:0] a;
        input [SW-1:0] m;
        begin
            pickStatus = useMul ? m : a;
        end
    endfunction

    // Operation class decode
    assign isAluOp = (opClass == `FSE_OP_ALU);
    assign isMulOp = (opClass == `FSE_OP_MUL);
    assign chained = (opClass == `FSE_OP_CHAIN);
    // Idle source contributes nothing so stale conditions never leak out
    assign aluOn = chained || isAluOp;
    assign mulOn = chained || isMulOp;

    // ALU flags; tiny covers denormal output and bad integer ops
    fse_source_status #(.W(SW)) uAlu (
        .isCompare(aluCompare),
        .opEqual(aluEqual),
        .opGreater(aluGreater),
        .opNanA(aluNanA),
        .opNanB(aluNanB),
        .opDenA(1'b0),
        .opDenB(1'b0),
        .resZero(aluZero),
        .resNeg(aluNeg),
        .resInf(aluInf),
        .resInexact(aluInexact),
        .resTooLarge(aluTooLarge),
        .resTooSmall(aluTooSmall),
        .resTiny(aluDenormOut || aluBadInteger),
        .invalidOp(aluInvalid),
        .zeroDivisor(1'b0),
        .roundCarry(aluRoundCarry),
        .isMul(1'b0),
        .status(aluSt)
    );

    // Multiplier flags; tiny means the product is wrapped
    fse_source_status #(.W(SW)) uMul (
        .isCompare(1'b0),
        .opEqual(1'b0),
        .opGreater(1'b0),
        .opNanA(mulNanA),
        .opNanB(mulNanB),
        .opDenA(mulDenA),
        .opDenB(mulDenB),
        .resZero(mulZero),
        .resNeg(mulNeg),
        .resInf(mulInf),
        .resInexact(mulInexact),
        .resTooLarge(mulTooLarge),
        .resTooSmall(mulTooSmall),
        .resTiny(mulWrapped),
        .invalidOp(mulInvalid),
        .zeroDivisor(mulZeroDivisor),
        .roundCarry(mulRoundCarry),
        .isMul(1'b1),
        .status(mulSt)
    );

    // Any exception of each source; chained mode flags the unselected one
    assign aluExc = anyException(aluSt);
    assign mulExc = anyException(mulSt);

    // Source selection; forced selects only matter in chained mode
    always @* begin
        selSt = {SW{1'b0}};
        selSrc = 1'b0;
        selChex = 1'b0;
        if (!chained) begin
            selSrc = isMulOp;
            selSt = pickStatus(selSrc, aluSt, mulSt);
        end else begin
            case (statusSelect)
                `FSE_SEL_OR: begin
                    selSt = aluSt | mulSt;
                    selSrc = resultSourceSelect;
                end
                `FSE_SEL_MUL: begin
                    selSt = mulSt;
                    selSrc = 1'b1;
                end
                `FSE_SEL_ALU: begin
                    selSt = aluSt;
                    selSrc = 1'b0;
                end
                default: begin
                    selSrc = resultSourceSelect;
                    selSt = pickStatus(resultSourceSelect, aluSt, mulSt);
                end
            endcase
            // Unselected source raising an exception
            selChex = resultSourceSelect ? aluExc : mulExc;
        end
        if (!aluOn && !mulOn) begin
            selSt = {SW{1'b0}};
        end
    end

    // Status register; left alone while bypassed so the last latched word survives
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `FSE_ST_RST;
            src_q <= 1'b0;
            chained_other_exception_q <= 1'b0;
        end else if (!outputStageBypass) begin
            stat_q <= selSt;
            src_q <= selSrc;
            chained_other_exception_q <= selChex;
        end
    end

    // Mask register, loaded by the controller; only the summary reads it
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `FSE_MASK_RST;
        end else if (maskLoad) begin
            mask_q <= maskData;
        end
    end

    // Registered when the stage is in use, direct when bypassed, aligned with data
    assign outSt = outputStageBypass ? selSt : stat_q;
    assign outSrc = outputStageBypass ? selSrc : src_q;
    assign outChex = outputStageBypass ? selChex : chained_other_exception_q;

    // Pin gating: low enable drives; flags stay readable whatever the mask
    assign compareOe = !compareOutputEnable_n;
    assign statusOe = !statusOutputEnable_n;
    assign operandsEqualFlag = compareOe & outSt[`FSE_ST_EQ];
    assign aGreaterFlag = compareOe & outSt[`FSE_ST_GT];
    assign nanCompareFlag = compareOe & outSt[`FSE_ST_NAN_COMPARE_FLAG];
    assign chainedOtherException = statusOe & outChex;

    // Exception field pins, one field bit each, and the sign pin
    assign denormalInputFlag = statusOe & outSt[`FSE_EX_DENORMAL_INPUT_FLAG];
    assign tinyResultFlag = statusOe & outSt[`FSE_EX_TINY];
    assign zeroDivisorFlag = statusOe & outSt[`FSE_EX_DIVZ];
    assign roundingLossFlag = statusOe & outSt[`FSE_EX_ROUNDING_LOSS_FLAG];
    assign unboundedResultFlag = statusOe & outSt[`FSE_EX_INF];
    assign badOperationFlag = statusOe & outSt[`FSE_EX_BAD_OPERATION_FLAG];
    assign signFlag = statusOe & outSt[`FSE_ST_NEG];
    assign tooLargeFlag = statusOe & outSt[`FSE_EX_OVER];
    assign tooSmallFlag = statusOe & outSt[`FSE_EX_UNDER];

    // Rounding, source and port pins, outside the exception field
    assign roundCarryFlag = statusOe & outSt[`FSE_ST_ROUND_CARRY_FLAG];
    assign statusSourceFlag = statusOe & outSrc;
    assign portBException = statusOe & outSt[`FSE_ST_PORTB];
    assign portAException = statusOe & outSt[`FSE_ST_PORTA];
    // Summary looks at the presented status through the mask
    assign outEx = outSt[EW-1:0];
    assign maskedEx = outEx & mask_q;
    assign maskedFaultSummary = statusOe & (|maskedEx);

    // Flush mode zeroes tiny or too-small results
    assign flushToZero = flushMode & (outSt[`FSE_EX_TINY] | outSt[`FSE_EX_UNDER]);
endmodule // fse_status_gen
`default_nettype wire

// File: fse_status_gen_sva.sv
// Port checker for the status and exception generator
`timescale 1ns/1ps
`default_nettype none
module fse_status_gen_sva (
    // Clock, reset and controls
    input wire clk, rst_n, outputStageBypass, resultSourceSelect, flushMode,
    input wire [1:0] opClass, statusSelect,
    input wire compareOutputEnable_n, statusOutputEnable_n,
    // Raw conditions
    input wire aluCompare, aluEqual, aluGreater, aluNanA, aluNanB, aluInf, aluTooLarge,
    input wire aluTooSmall, aluDenormOut, aluBadInteger, aluInexact, mulTooLarge,
    // Watched pins
    input wire operandsEqualFlag, aGreaterFlag, nanCompareFlag, compareOe, statusOe,
    input wire chainedOtherException, denormalInputFlag, zeroDivisorFlag, tooLargeFlag,
    input wire statusSourceFlag, maskedFaultSummary, flushToZero
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Equal-compare condition taken into the register, seen a cycle later
    wire eqTaken;
    assign eqTaken = rst_n && !outputStageBypass && opClass == 2'h0 && aluCompare && aluEqual;
    // Released enables leave every watched flag low except flushToZero, which is not gated, summary too
    a_cmp_gate_off: assert property (compareOutputEnable_n |-> !(operandsEqualFlag | aGreaterFlag | nanCompareFlag))
        else $error("compare flags high while released");
    a_stat_gate_off: assert property (statusOutputEnable_n |-> !(chainedOtherException | denormalInputFlag |
        zeroDivisorFlag | tooLargeFlag | statusSourceFlag | maskedFaultSummary)) else $error("status high while released");
    a_oe_follow: assert property (compareOe == !compareOutputEnable_n && statusOe == !statusOutputEnable_n)
        else $error("output enable wrong");
    // Latched path shows last edge's compare result
    a_latch_equal: assert property (!outputStageBypass && !compareOutputEnable_n && $past(eqTaken)
        |-> operandsEqualFlag) else $error("latched equal lost");
    a_bypass_compare: assert property (outputStageBypass && !compareOutputEnable_n && opClass == 2'h0 && aluCompare
        |-> operandsEqualFlag == aluEqual) else $error("bypassed equal wrong");
    a_gt_nan_compare_flag: assert property (outputStageBypass && !compareOutputEnable_n && opClass == 2'h0 && aluCompare
        |-> aGreaterFlag == aluGreater && nanCompareFlag == (aluNanA | aluNanB)) else $error("greater or unordered wrong");
    a_alu_suppress: assert property (outputStageBypass && !statusOutputEnable_n && opClass == 2'h0
        |-> !zeroDivisorFlag && !denormalInputFlag && !statusSourceFlag) else $error("multiplier status leaked");
    a_chained_other_exception_alu: assert property (outputStageBypass && !statusOutputEnable_n && opClass == 2'h2 && resultSourceSelect
        && (aluTooLarge | aluInf) |-> chainedOtherException) else $error("chained exception missed");
    a_or_select: assert property (outputStageBypass && !statusOutputEnable_n && opClass == 2'h2 && statusSelect == 2'h0
        |-> tooLargeFlag == (aluTooLarge | mulTooLarge)) else $error("or select wrong");
    a_flush_zero: assert property (outputStageBypass && opClass == 2'h0
        |-> flushToZero == (flushMode && ((aluTooSmall & aluInexact) | aluDenormOut | aluBadInteger)))
        else $error("flush wrong");
    // Main scenarios reached
    c_or_mode: cover property (opClass == 2'h2 && statusSelect == 2'h0);
    c_summary: cover property (maskedFaultSummary);
    c_latched_eq: cover property (!outputStageBypass && operandsEqualFlag);
endmodule // fse_status_gen_sva
bind fse_status_gen fse_status_gen_sva u_sva (.clk, .rst_n, .outputStageBypass, .resultSourceSelect, .flushMode,
    .opClass, .statusSelect, .compareOutputEnable_n, .statusOutputEnable_n, .aluCompare, .aluEqual, .aluGreater,
    .aluNanA, .aluNanB, .aluInf, .aluTooLarge, .aluTooSmall, .aluDenormOut, .aluBadInteger,
    .aluInexact, .mulTooLarge,
    .operandsEqualFlag, .aGreaterFlag, .nanCompareFlag, .compareOe, .statusOe, .chainedOtherException,
    .denormalInputFlag, .zeroDivisorFlag, .tooLargeFlag, .statusSourceFlag, .maskedFaultSummary, .flushToZero);
`default_nettype wire

// File: fse_ctl_model.sv
// Microprogram controller model: decodes a command word onto the control pins
`timescale 1ns/1ps
`default_nettype none
module fse_ctl_model (
    // Command word, changed just after a clock edge
    input wire logic [17:0] cmd,
    // Control pins of the generator
    output wire logic outputStageBypass,
    output wire logic [1:0] opClass,
    output wire logic [1:0] statusSelect,
    output wire logic resultSourceSelect,
    output wire logic flushMode,
    output wire logic compareOutputEnable_n,
    output wire logic statusOutputEnable_n,
    output wire logic maskLoad,
    output wire logic [7:0] maskData
);
    // Plain decode, so pins move only when the word does
    assign outputStageBypass = cmd[0];
    assign opClass = cmd[2:1];
    assign statusSelect = cmd[4:3];
    assign resultSourceSelect = cmd[5];
    assign flushMode = cmd[6];
    assign {statusOutputEnable_n, compareOutputEnable_n} = cmd[8:7];
    assign maskLoad = cmd[9];
    assign maskData = cmd[17:10];
endmodule // fse_ctl_model
`default_nettype wire

// File: fse_status_gen_tb.sv
// Self-checking bench for the status and exception generator
`timescale 1ns/1ps
`default_nettype none
module fse_status_gen_tb;
    // Clock, reset, stimulus and score
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [17:0] cmd = 18'h00000;
    logic [14:0] alu = 15'h0000;
    logic [13:0] mul = 14'h0000;
    logic [7:0] maskQ = 8'h00;
    integer seed = 6418, errors = 0, total_checks = 0, cyc = 0, i;
    wire outputStageBypass, resultSourceSelect, flushMode, compareOutputEnable_n, statusOutputEnable_n, maskLoad;
    wire [1:0] opClass, statusSelect;
    wire [7:0] maskData;
    wire operandsEqualFlag, aGreaterFlag, nanCompareFlag, compareOe, chainedOtherException, denormalInputFlag;
    wire tinyResultFlag, zeroDivisorFlag, roundingLossFlag, unboundedResultFlag, badOperationFlag, signFlag;
    wire tooLargeFlag, tooSmallFlag, roundCarryFlag, statusSourceFlag, portBException, portAException;
    wire maskedFaultSummary, statusOe, flushToZero;
    wire [7:0] exSeen = {unboundedResultFlag, denormalInputFlag, zeroDivisorFlag, badOperationFlag,
        roundingLossFlag, tinyResultFlag, tooSmallFlag, tooLargeFlag};
    always #25 clk = ~clk;
    fse_ctl_model ctl (.cmd, .outputStageBypass, .opClass, .statusSelect, .resultSourceSelect, .flushMode,
        .compareOutputEnable_n, .statusOutputEnable_n, .maskLoad, .maskData);
    fse_status_gen dut (.clk, .rst_n, .outputStageBypass, .opClass, .statusSelect, .resultSourceSelect, .flushMode,
        .compareOutputEnable_n, .statusOutputEnable_n, .maskLoad, .maskData, .aluCompare(alu[14]),
        .aluEqual(alu[13]), .aluGreater(alu[12]), .aluNanA(alu[11]), .aluNanB(alu[10]), .aluZero(alu[9]),
        .aluNeg(alu[8]), .aluInf(alu[7]), .aluInexact(alu[6]), .aluTooLarge(alu[5]), .aluTooSmall(alu[4]),
        .aluDenormOut(alu[3]), .aluBadInteger(alu[2]), .aluInvalid(alu[1]), .aluRoundCarry(alu[0]),
        .mulNanA(mul[13]), .mulNanB(mul[12]), .mulDenA(mul[11]), .mulDenB(mul[10]), .mulZero(mul[9]),
        .mulNeg(mul[8]), .mulInf(mul[7]), .mulInexact(mul[6]), .mulTooLarge(mul[5]), .mulTooSmall(mul[4]),
        .mulWrapped(mul[3]), .mulInvalid(mul[2]), .mulZeroDivisor(mul[1]), .mulRoundCarry(mul[0]),
        .operandsEqualFlag, .aGreaterFlag, .nanCompareFlag, .compareOe, .chainedOtherException, .denormalInputFlag,
        .tinyResultFlag, .zeroDivisorFlag, .roundingLossFlag, .unboundedResultFlag, .badOperationFlag, .signFlag,
        .tooLargeFlag, .tooSmallFlag, .roundCarryFlag, .statusSourceFlag, .portBException, .portAException,
        .maskedFaultSummary, .statusOe, .flushToZero);
    // Exception fields: inf, denormal_input_flag, divzero, invalid, inexact, tiny, under, over
    function automatic [7:0] exAlu(input logic [14:0] a);
        exAlu = {a[7], 2'b00, a[1] | a[11] | a[10], a[6], a[3] | a[2], a[4] & a[6], a[5]};
    endfunction
    function automatic [7:0] exMul(input logic [13:0] m);
        exMul = {m[7], m[11] | m[10], m[1], m[2] | m[13] | m[12], m[6], m[3], m[4] & m[6], m[5]};
    endfunction
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task end_sim;
        if (errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Expected pins from the held inputs; OR select leaves sign, round carry, port and compare flags unchecked
    task automatic check_out;
        logic useMul, orSel, sOn, cOn;
        logic [7:0] ex;
        logic [3:0] nx;
        logic [2:0] cp;
        useMul = opClass == 2'h1 || (opClass == 2'h2 && (statusSelect == 2'h1 || (statusSelect == 2'h3 && resultSourceSelect)));
        orSel = opClass == 2'h2 && statusSelect == 2'h0;
        sOn = !statusOutputEnable_n;
        cOn = !compareOutputEnable_n;
        ex = opClass == 2'h3 ? 8'h00 : orSel ? exAlu(alu) | exMul(mul) : useMul ? exMul(mul) : exAlu(alu);
        nx = useMul ? {mul[8], mul[0], mul[12] | mul[10], mul[13] | mul[11]} : {alu[8], alu[0], alu[10], alu[11]};
        cp = useMul ? {mul[9], 2'b00} : alu[14] ? {alu[13], alu[12], alu[11] | alu[10]} : {alu[9], 2'b00};
        if (opClass == 2'h3) begin
            nx = 4'h0;
            cp = 3'h0;
        end
        chk("exceptions", ex & {8{sOn}}, exSeen);
        chk("summary", 8'(|(ex & maskQ) & sOn), 8'(maskedFaultSummary));
        chk("flush", 8'(flushMode & (ex[2] | ex[1])), 8'(flushToZero));
        chk("chained", 8'(opClass == 2'h2 && (resultSourceSelect ? |exAlu(alu) : |exMul(mul)) && sOn),
            8'(chainedOtherException));
        chk("source", 8'((opClass != 2'h3) && (orSel ? resultSourceSelect : useMul) && sOn), 8'(statusSourceFlag));
        chk("enables", {6'h00, cOn, sOn}, {6'h00, compareOe, statusOe});
        if (!orSel) begin
            chk("status", 8'(nx & {4{sOn}}), {4'h0, signFlag, roundCarryFlag, portBException, portAException});
            chk("compare", 8'(cp & {3{cOn}}), {5'h00, operandsEqualFlag, aGreaterFlag, nanCompareFlag});
        end
    endtask
    // One transfer: set at an edge, latched at the next, read mid-cycle
    task automatic step(input logic [17:0] c, input logic [14:0] a, input logic [13:0] m);
        @(posedge clk);
        cmd <= c;
        alu <= a;
        mul <= m;
        @(posedge clk);
        if (maskLoad)
            maskQ = maskData;
        @(negedge clk);
        check_out;
    endtask
    // Hang guard, well above the planned run length
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            end_sim;
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        step(18'h00000, 15'h6000, 14'h0000);
        for (i = 0; i < 64; i++)
            step({8'($random(seed)), 1'b1, 2'b00, 1'($random(seed)), i[0], i[2:1], i[4:3], i[5]},
                15'($random(seed)), 14'($random(seed)));
        for (i = 0; i < 200; i++)
            step(18'($random(seed)), 15'($random(seed)), 14'($random(seed)));
        @(posedge clk);
        cmd <= 18'h00000;
        alu <= 15'h7fff;
        mul <= 14'h3fff;
        rst_n <= 1'b0;
        maskQ = 8'h00;
        @(negedge clk);
        chk("reset", 8'h00, {exSeen[7:1], maskedFaultSummary | operandsEqualFlag});
        @(posedge clk);
        rst_n <= 1'b1;
        step(18'h00000, 15'h7fff, 14'h3fff);
        for (i = 0; i < 200; i++)
            step(18'($random(seed)), 15'($random(seed)), 14'($random(seed)));
        end_sim;
    end
endmodule // fse_status_gen_tb
`default_nettype wire
